/* File: alt_pkg.sv */
// Constants for the accumulator load transfer decoder
package alt_pkg;

    // ------------------------------------------------------------
    // Opcode encodings
    // ------------------------------------------------------------
    localparam logic [9:0] ALT_OP_READ_DISPLAY_CTRL = 10'h24a;
    localparam logic [9:0] ALT_OP_READ_CONV_LOW     = 10'h24f;
    localparam logic [9:0] ALT_OP_READ_CLOCK_CTRL   = 10'h252;
    localparam logic [5:0] ALT_OP_RAM_TO_ACC_HI     = 6'h2c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ALT_OP_HI_MSB  = 9;
    localparam int ALT_OP_HI_LSB  = 4;
    localparam int ALT_IMM_MSB    = 3;

    // ------------------------------------------------------------
    // Reset values and cycle counts
    // ------------------------------------------------------------
    localparam logic [3:0] ALT_ACC_RESET      = 4'h0;
    localparam logic [3:0] ALT_FILE_SEL_RESET = 4'h0;
    localparam int         ALT_EXEC_CYCLES    = 1;

    typedef enum logic [2:0]
    {
        ALT_NONE,
        ALT_DISPLAY,
        ALT_CONV,
        ALT_RAM,
        ALT_CLOCK
    } alt_op_t;

endpackage

/* File: alt_core.sv */
// Decoder and executor for four transfer-to-accumulator instructions
// Functional notes
// [RULE1] Opcode 0x24a copies the display control register into the accumulator in one cycle.
// [RULE2] The conversion result read puts result bits 1 and 0 into accumulator bits 3 and 2.
// [RULE3] The conversion result read clears accumulator bits 1 and 0.
// [RULE4] Opcodes 0x2c0 to 0x2cf are the RAM-to-accumulator transfer with a 4-bit immediate.
// [RULE5] Load the accumulator from RAM, then XOR the file selector with the immediate.
// [RULE6] Opcode 0x252 copies the clock control register into the accumulator in one cycle.
// [RULE7] None of the four changes the carry flag or requests a skip; of the four, only the RAM transfer alters its source (it XORs the file selector).
module alt_core
    import alt_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       instr_valid_in,
    input  wire logic [9:0] instr_in,
    input  wire logic [3:0] display_ctrl_reg_in,
    input  wire logic [3:0] clock_ctrl_reg_in,
    input  wire logic       conv_result_bit1_in,
    input  wire logic       conv_result_bit0_in,
    input  wire logic [3:0] ram_data_in,
    input  wire logic       acc_load_in,
    input  wire logic [3:0] acc_data_in,
    input  wire logic       file_sel_load_in,
    input  wire logic [3:0] file_sel_data_in,
    output logic [3:0]      acc_out,
    output logic [3:0]      file_sel_out,
    output logic            hit_out,
    output logic            carry_we_out,
    output logic            skip_next_out
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Exact codes first; the RAM group is matched on its six-bit prefix
    function automatic alt_op_t alt_decode(input logic [9:0] op);
        alt_op_t r;
        r = ALT_NONE;
        if (op == ALT_OP_READ_DISPLAY_CTRL)
            r = ALT_DISPLAY; // RULE1
        else if (op == ALT_OP_READ_CONV_LOW)
            r = ALT_CONV; // RULE2
        else if (op == ALT_OP_READ_CLOCK_CTRL)
            r = ALT_CLOCK; // RULE6
        else if (op[ALT_OP_HI_MSB:ALT_OP_HI_LSB] == ALT_OP_RAM_TO_ACC_HI)
            r = ALT_RAM; // RULE4
        return r;
    endfunction

    alt_op_t    op;
    logic [3:0] next_acc;
    logic [3:0] acc;
    logic [3:0] file_sel;

    // A bubble slot decodes to nothing, whatever its opcode bits hold
    always_comb
    begin
        op = instr_valid_in ? alt_decode(instr_in) : ALT_NONE;
    end

    assign hit_out       = (op != ALT_NONE);
    // Tied low: none of these transfers writes carry or skips
    assign carry_we_out  = 1'b0; // RULE7
    assign skip_next_out = 1'b0; // RULE7
    assign acc_out       = acc;
    assign file_sel_out  = file_sel;

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------
    // A decoded transfer wins over a load from another unit
    always_comb
    begin
        next_acc = acc;
        unique case (op)
            ALT_NONE:    next_acc = acc_load_in ? acc_data_in : acc;
            ALT_DISPLAY: next_acc = display_ctrl_reg_in; // RULE1
            ALT_CONV:    next_acc = {conv_result_bit1_in, conv_result_bit0_in, // RULE2
                                     2'h0}; // RULE3
            ALT_RAM:     next_acc = ram_data_in; // RULE5
            ALT_CLOCK:   next_acc = clock_ctrl_reg_in; // RULE6
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            acc <= ALT_ACC_RESET;
        else
            acc <= next_acc;
    end

    // ------------------------------------------------------------
    // RAM file selector
    // ------------------------------------------------------------
    // RAM is read with the old selector; the XOR lands on the same edge
    // The XOR outranks a load from another unit in the same cycle
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            file_sel <= ALT_FILE_SEL_RESET;
        else if (op == ALT_RAM)
            file_sel <= file_sel ^ instr_in[ALT_IMM_MSB:0]; // RULE5
        else if (file_sel_load_in)
            file_sel <= file_sel_data_in;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    display_read_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE1
        (instr_valid_in && instr_in == 10'h24a) |=> acc == $past(display_ctrl_reg_in))
        else $error("display control read wrong");

    conv_high_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE2
        (op == ALT_CONV) |=>
            acc[3:2] == {$past(conv_result_bit1_in), $past(conv_result_bit0_in)})
        else $error("conversion bits misplaced");

    conv_low_zero_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE3
        (op == ALT_CONV) |=> acc[1:0] == 2'h0)
        else $error("conversion low bits not cleared");

    ram_decode_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE4
        (instr_valid_in && instr_in[9:4] == 6'h2c) |-> (op == ALT_RAM && hit_out))
        else $error("RAM transfer not decoded");

    ram_load_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE5
        (op == ALT_RAM) |=> acc == $past(ram_data_in)
            && file_sel == ($past(file_sel) ^ $past(instr_in[3:0])))
        else $error("RAM transfer result wrong");

    clock_read_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE6
        (instr_valid_in && instr_in == 10'h252) |=> acc == $past(clock_ctrl_reg_in))
        else $error("clock control read wrong");

    no_side_effect_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE7
        hit_out |-> (!carry_we_out && !skip_next_out))
        else $error("transfer touched carry or skip");

    sel_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE7
        (hit_out && op != ALT_RAM && !file_sel_load_in) |=> $stable(file_sel))
        else $error("file selector changed by register read");

    idle_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!hit_out && !acc_load_in) |=> $stable(acc))
        else $error("accumulator changed while idle");

    // ------------------------------------------------------------
    // Decode, load and reset checks
    // ------------------------------------------------------------
    display_decode_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE1
        (instr_valid_in && instr_in == ALT_OP_READ_DISPLAY_CTRL)
            |-> (op == ALT_DISPLAY && hit_out))
        else $error("display control read not decoded");

    conv_decode_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE2
        (instr_valid_in && instr_in == ALT_OP_READ_CONV_LOW)
            |-> (op == ALT_CONV && hit_out))
        else $error("conversion read not decoded");

    clock_decode_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE6
        (instr_valid_in && instr_in == ALT_OP_READ_CLOCK_CTRL)
            |-> (op == ALT_CLOCK && hit_out))
        else $error("clock control read not decoded");

    ram_exact_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE4
        (op == ALT_RAM)
            |-> (instr_in[ALT_OP_HI_MSB:ALT_OP_HI_LSB] == ALT_OP_RAM_TO_ACC_HI))
        else $error("RAM transfer decoded from a foreign opcode");

    // Both writers in one cycle: the transfer must win
    ram_priority_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE5
        (op == ALT_RAM && file_sel_load_in)
            |=> file_sel == ($past(file_sel) ^ $past(instr_in[ALT_IMM_MSB:0])))
        else $error("file selector load beat the RAM transfer");

    // A zero immediate is the only one that keeps the selector
    ram_imm_zero_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE5
        (op == ALT_RAM && instr_in[ALT_IMM_MSB:0] == 4'h0)
            |=> $stable(file_sel))
        else $error("zero immediate moved the file selector");

    // Anything outside the four encodings must not raise hit_out
    unknown_op_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (instr_valid_in && instr_in != ALT_OP_READ_DISPLAY_CTRL
            && instr_in != ALT_OP_READ_CONV_LOW && instr_in != ALT_OP_READ_CLOCK_CTRL
            && instr_in[ALT_OP_HI_MSB:ALT_OP_HI_LSB] != ALT_OP_RAM_TO_ACC_HI)
            |-> !hit_out)
        else $error("unknown opcode decoded");

    // Opcode bits in an empty slot are don't-care
    invalid_quiet_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !instr_valid_in |-> (op == ALT_NONE && !hit_out))
        else $error("decode active without a valid instruction");

    // Other units share the accumulator; their load must land when no transfer is decoded
    acc_load_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!hit_out && acc_load_in) |=> acc == $past(acc_data_in))
        else $error("accumulator load from other unit lost");

    sel_load_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (op != ALT_RAM && file_sel_load_in) |=> file_sel == $past(file_sel_data_in))
        else $error("file selector load lost");

    sel_idle_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!hit_out && !file_sel_load_in) |=> $stable(file_sel))
        else $error("file selector changed while idle");

    // No disable here: this one watches the reset itself
    reset_value_a: assert property (@(posedge clk_in)
        !rstn_in |=> (acc == ALT_ACC_RESET && file_sel == ALT_FILE_SEL_RESET))
        else $error("state not cleared by reset");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    display_c: cover property (@(posedge clk_in) disable iff (!rstn_in) op == ALT_DISPLAY);
    conv_c:    cover property (@(posedge clk_in) disable iff (!rstn_in) op == ALT_CONV);
    ram_c:     cover property (@(posedge clk_in) disable iff (!rstn_in)
        op == ALT_RAM ##1 op == ALT_RAM);
    clock_c:   cover property (@(posedge clk_in) disable iff (!rstn_in) op == ALT_CLOCK);
    sel_clash_c: cover property (@(posedge clk_in) disable iff (!rstn_in)
        op == ALT_RAM && file_sel_load_in);

endmodule // alt_core

/* File: test_acc_load_transfer_ops.sv */
// Self-checking bench for the accumulator load transfer decoder
module test_acc_load_transfer_ops
    import alt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_in, rstn_in, instr_valid_in, bit1, bit0, acc_ld, fs_ld;
    logic [9:0]  instr_in;
    logic [3:0]  disp, clkr, ram, acc_d, fs_d;
    logic [3:0]  acc_out, file_sel_out;
    logic        hit_out, carry_we_out, skip_next_out, exp_hit;
    logic [31:0] r;
    int          num_errors, comparisons, cycles, exp_acc, exp_fs;
    int          seed = 32'hab64;

    alt_core dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .display_ctrl_reg_in(disp), .clock_ctrl_reg_in(clkr),
        .conv_result_bit1_in(bit1), .conv_result_bit0_in(bit0), .ram_data_in(ram),
        .acc_load_in(acc_ld), .acc_data_in(acc_d), .file_sel_load_in(fs_ld),
        .file_sel_data_in(fs_d), .acc_out(acc_out), .file_sel_out(file_sel_out),
        .hit_out(hit_out), .carry_we_out(carry_we_out), .skip_next_out(skip_next_out));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task check(input logic [3:0] seen, input logic [3:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // Ceiling well above the roughly 800 cycles the run needs
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            wrap_up;
        end
    end

    // ------------------------------------------------------------
    // Random instruction stream against the model
    // ------------------------------------------------------------
    initial
    begin
        {rstn_in, instr_valid_in, instr_in, disp, clkr, ram, acc_d, fs_d} = '0;
        {bit1, bit0, acc_ld, fs_ld} = '0;
        exp_acc = 0;
        exp_fs = 0;
        repeat (2) @(posedge clk_in);
        #1;
        check(acc_out, ALT_ACC_RESET);
        rstn_in = 1'b1;
        for (int i = 0; i < 800; i++)
        begin
            @(posedge clk_in);
            #1;
            check(acc_out, 4'(exp_acc));
            check(file_sel_out, 4'(exp_fs));
            r = $random(seed);
            {disp, clkr, ram, acc_d, fs_d, bit1, bit0, acc_ld, fs_ld, instr_valid_in} = r[24:0];
            instr_valid_in = instr_valid_in | r[25];
            case (r[29:27])
                3'h0: instr_in = ALT_OP_READ_DISPLAY_CTRL;
                3'h1: instr_in = ALT_OP_READ_CONV_LOW;
                3'h2: instr_in = ALT_OP_READ_CLOCK_CTRL;
                3'h3, 3'h4: instr_in = {ALT_OP_RAM_TO_ACC_HI, r[3:0] ^ r[31:28]};
                default: instr_in = 10'($random(seed));
            endcase
            exp_hit = instr_valid_in && (instr_in == ALT_OP_READ_DISPLAY_CTRL
                || instr_in == ALT_OP_READ_CONV_LOW || instr_in == ALT_OP_READ_CLOCK_CTRL
                || instr_in[9:4] == ALT_OP_RAM_TO_ACC_HI);
            #1;
            check({3'h0, hit_out}, {3'h0, exp_hit});
            check({2'h0, carry_we_out, skip_next_out}, 4'h0);
            if (exp_hit && instr_in[9:4] == ALT_OP_RAM_TO_ACC_HI)
            begin
                exp_acc = ram;
                exp_fs = exp_fs ^ instr_in[3:0];
            end
            else
            begin
                if (fs_ld)
                    exp_fs = fs_d;
                if (exp_hit)
                    exp_acc = (instr_in == ALT_OP_READ_DISPLAY_CTRL) ? disp
                        : (instr_in == ALT_OP_READ_CLOCK_CTRL) ? clkr : {bit1, bit0, 2'b00};
                else if (acc_ld)
                    exp_acc = acc_d;
            end
        end
        @(posedge clk_in);
        #1;
        check(acc_out, 4'(exp_acc));
        check(file_sel_out, 4'(exp_fs));
        wrap_up;
    end
endmodule // test_acc_load_transfer_ops
